// *** dzs_zone_switch.sv ***
// Teach-in, zone detection and indicator logic for modes 2 and 3, with an
// Avalon-MM register slave. Assumes distance samples arrive on CLOCK with
// a one-cycle valid strobe, and keys are asynchronous active-low pins.
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module dzs_zone_switch
    import dzs_pkg::*;
#(
    parameter int TICK_CYC  = MS_TICK_CYC,
    parameter int BUF_DEPTH = BUF_DEPTH_DEF
) (
    input  wire logic        CLOCK,
    input  wire logic        SRST,
    input  wire logic [15:0] DIST,
    input  wire logic        DIST_VALID,
    input  wire logic        TEACH_KEY_N,
    input  wire logic        SET_KEY_N,
    input  wire logic [7:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    output logic             IRQ,
    output logic             SWITCH_OUT,
    output logic             LED1_GREEN,
    output logic             LED1_RED,
    output logic             LED2_GREEN,
    output logic             LED2_RED
);
    localparam int DIV_W = $clog2(TICK_CYC);

    logic [DIV_W-1:0]     div_q;
    logic                 tick_q;
    logic                 key_raw [2];
    logic                 key_m_q [2];
    logic                 key_s_q [2];
    logic                 key_db_q [2];
    logic [3:0]           db_cnt_q [2];
    logic                 teach_prev_q, set_prev_q;
    logic                 set_press, teach_edge, teach_long;
    logic [15:0]          hold_q;
    logic [15:0]          last_q;
    dzs_state_t           state_q;
    logic [15:0]          bg_q, lim1_q, lim2_q, step_q;
    logic                 taught_q, tmo_q;
    logic [1:0]           ctrl_q;
    logic [15:0]          delay_lim_q, pulse_lim_q, idle_lim_q;
    logic                 run, samp, mode3, beyond, act3;
    logic                 obj_q, sw_q, det_q, push_q;
    logic [15:0]          rec_q, pulse_q, flash_q, blink_cnt_q;
    logic                 blink_q;
    logic [1:0]           zone_q;
    logic [3:0]           led_d, led_q;
    logic [15:0]          buf_q [BUF_DEPTH];
    logic                 ack_q, irq_q;
    logic [31:0]          rdata_q, rmux;
    logic [IRQ_W-1:0]     stat_q, mask_q, ev;
    logic                 wr_en, rd_clr;

    // True on the tick that completes a count of lim milliseconds
    function automatic logic done16(input logic [15:0] cnt, input logic [15:0] lim);
        return ({1'b0, cnt} + 17'h00001) >= {1'b0, lim};
    endfunction

    // Byte-lane merge for 16-bit registers
    function automatic logic [15:0] be16(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
        return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // Millisecond enable; all slow timing counts these ticks
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else if (div_q == DIV_W'(TICK_CYC - 1)) begin
            div_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    assign key_raw[0] = ~TEACH_KEY_N;
    assign key_raw[1] = ~SET_KEY_N;

    // Two-stage sync, then a level must stay stable for the debounce time
    generate
        for (genvar g = 0; g < 2; g++) begin : g_key
            always_ff @(posedge CLOCK) begin
                if (SRST) begin
                    key_m_q[g]  <= 1'b0;
                    key_s_q[g]  <= 1'b0;
                    key_db_q[g] <= 1'b0;
                    db_cnt_q[g] <= '0;
                end else begin
                    key_m_q[g] <= key_raw[g];
                    key_s_q[g] <= key_m_q[g];
                    if (key_s_q[g] == key_db_q[g]) begin
                        db_cnt_q[g] <= '0;
                    end else if (tick_q) begin
                        if (db_cnt_q[g] == DEBOUNCE_MS - 4'h1) begin
                            key_db_q[g] <= key_s_q[g];
                            db_cnt_q[g] <= '0;
                        end else begin
                            db_cnt_q[g] <= db_cnt_q[g] + 4'h1;
                        end
                    end
                end
            end
        end
    endgenerate

    // Key edges and teach hold time; long press fires once per press
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            teach_prev_q <= 1'b0;
            set_prev_q   <= 1'b0;
            hold_q       <= '0;
        end else begin
            teach_prev_q <= key_db_q[0];
            set_prev_q   <= key_db_q[1];
            if (!key_db_q[0]) begin
                hold_q <= '0;
            end else if (tick_q && hold_q != HOLD_CNT) begin
                hold_q <= hold_q + 16'h0001;
            end
        end
    end

    assign set_press  = key_db_q[1] & ~set_prev_q;
    assign teach_edge = key_db_q[0] & ~teach_prev_q;
    assign teach_long = tick_q & key_db_q[0] & (hold_q == HOLD_CNT - 16'h0001);

    // Latest distance, the value captured by any teach step
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            last_q <= BG_RST;
        end else if (DIST_VALID) begin
            last_q <= DIST;
        end
    end

    // Setup sequence; mode is sampled only when teaching starts
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            state_q  <= ST_RUN;
            bg_q     <= BG_RST;
            lim1_q   <= '0;
            lim2_q   <= '0;
            step_q   <= '0;
            taught_q <= 1'b0;
            tmo_q    <= 1'b0;
        end else begin
            taught_q <= 1'b0;
            tmo_q    <= 1'b0;
            case (state_q)
                ST_RUN: begin
                    step_q <= '0;
                    if (teach_long) begin
                        bg_q    <= last_q;
                        state_q <= mode3 ? ST_WAIT_L1 : ST_DELAY;
                    end
                end
                ST_WAIT_L1, ST_WAIT_L2: begin
                    if (set_press && state_q == ST_WAIT_L1) begin
                        lim1_q  <= last_q;
                        state_q <= ST_WAIT_L2;
                        step_q  <= '0;
                    end else if (set_press && last_q > lim1_q) begin
                        lim2_q  <= last_q;
                        state_q <= ST_DELAY;
                        step_q  <= '0;
                    end else if (set_press || teach_edge) begin
                        step_q  <= '0; // A rejected press still counts as activity
                    end else if (tick_q) begin
                        if (done16(step_q, idle_lim_q)) begin
                            state_q <= ST_RUN;
                            tmo_q   <= 1'b1;
                        end else begin
                            step_q <= step_q + 16'h0001;
                        end
                    end
                end
                ST_DELAY: begin
                    if (tick_q) begin
                        if (done16(step_q, delay_lim_q)) begin
                            state_q  <= ST_RUN;
                            taught_q <= 1'b1;
                            step_q   <= '0;
                        end else begin
                            step_q <= step_q + 16'h0001;
                        end
                    end
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    // Zone comparison on the incoming sample
    assign run    = (state_q == ST_RUN);
    assign samp   = DIST_VALID & run;
    assign mode3  = ctrl_q[CTRL_MODE3];
    assign beyond = (DIST >= bg_q);
    assign act3   = ctrl_q[CTRL_REGION]
                  ? (((DIST >= MIN_DIST_MM) && (DIST < lim1_q)) || ((DIST > lim2_q) && !beyond))
                  : ((DIST > lim1_q) && (DIST < lim2_q) && !beyond);

    // Detection and switching output; setup forces the output inactive
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            obj_q   <= 1'b0;
            sw_q    <= 1'b0;
            det_q   <= 1'b0;
            push_q  <= 1'b0;
            rec_q   <= '0;
            pulse_q <= '0;
            zone_q  <= ZN_BACK;
        end else begin
            det_q  <= 1'b0;
            push_q <= 1'b0;
            if (!run) begin
                obj_q   <= 1'b0;
                sw_q    <= 1'b0;
                pulse_q <= '0;
                zone_q  <= ZN_BACK;
            end else if (!mode3) begin
                if (samp && !beyond) begin
                    obj_q <= 1'b1;
                    rec_q <= DIST;
                end else if (samp && obj_q) begin
                    obj_q   <= 1'b0; // Back at background: object has left
                    det_q   <= 1'b1;
                    push_q  <= 1'b1;
                    pulse_q <= pulse_lim_q;
                    sw_q    <= (pulse_lim_q != 16'h0000);
                end else if (tick_q && sw_q) begin
                    // One extra tick, so a part-tick start never cuts the pulse short
                    if (pulse_q == 16'h0000) begin
                        sw_q <= 1'b0;
                    end else begin
                        pulse_q <= pulse_q - 16'h0001;
                    end
                end
            end else if (samp) begin
                sw_q <= act3;
                if (act3) begin
                    rec_q <= DIST;
                end
                det_q  <= act3 & ~sw_q;
                push_q <= ~act3 & sw_q;
                if (beyond) begin
                    zone_q <= ZN_BACK;
                end else if (DIST <= lim1_q) begin
                    zone_q <= ZN_NEAR;
                end else if (DIST < lim2_q) begin
                    zone_q <= ZN_WIN;
                end else begin
                    zone_q <= ZN_FAR;
                end
            end
        end
    end

    // Blink base and the single mode 2 flash
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            blink_cnt_q <= '0;
            blink_q     <= 1'b0;
            flash_q     <= '0;
        end else begin
            if (tick_q) begin
                if (done16(blink_cnt_q, BLINK_MS)) begin
                    blink_cnt_q <= '0;
                    blink_q     <= ~blink_q;
                end else begin
                    blink_cnt_q <= blink_cnt_q + 16'h0001;
                end
            end
            if (det_q && !mode3) begin
                flash_q <= BLINK_MS;
            end else if (tick_q && flash_q != 16'h0000) begin
                flash_q <= flash_q - 16'h0001;
            end
        end
    end

    // Indicators as {LED1 green, LED1 red, LED2 green, LED2 red}
    always_comb begin
        led_d = 4'h0;
        case (state_q)
            ST_RUN: begin
                if (!mode3) begin
                    led_d = (flash_q != 16'h0000) ? 4'h0 : 4'hA;
                end else begin
                    case (zone_q)
                        ZN_NEAR: led_d = 4'h4;
                        ZN_WIN:  led_d = blink_q ? 4'hA : 4'h0;
                        ZN_FAR:  led_d = 4'h1;
                        default: led_d = 4'hA;
                    endcase
                end
            end
            ST_WAIT_L1: led_d = {blink_q, 3'h0};
            ST_WAIT_L2: led_d = {2'h2, blink_q, 1'b0};
            ST_DELAY:   led_d = 4'h0;
            default:    led_d = 4'h0;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            led_q <= 4'hA;
        end else begin
            led_q <= led_d;
        end
    end

    assign {LED1_GREEN, LED1_RED, LED2_GREEN, LED2_RED} = led_q;
    assign SWITCH_OUT = sw_q;

    // Rolling buffer; entry 0 is the newest, the last entry drops out
    generate
        for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_buf
            always_ff @(posedge CLOCK) begin
                if (SRST) begin
                    buf_q[i] <= '0;
                end else if (push_q) begin
                    buf_q[i] <= (i == 0) ? rec_q : buf_q[(i == 0) ? 0 : i - 1];
                end
            end
        end
    endgenerate

    // Avalon slave: one wait cycle, read data latched in the first cycle
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
    assign wr_en           = AVS_WRITE & ack_q;
    assign rd_clr          = AVS_READ & ack_q & (AVS_ADDRESS == REG_IRQ_STAT);
    assign ev              = {push_q, tmo_q, taught_q, det_q};

    always_comb begin
        rmux = 32'h0000_0000;
        case (AVS_ADDRESS)
            REG_CTRL:     rmux = {30'h0, ctrl_q};
            REG_DELAY:    rmux = {16'h0, delay_lim_q};
            REG_PULSE:    rmux = {16'h0, pulse_lim_q};
            REG_IDLE:     rmux = {16'h0, idle_lim_q};
            REG_STATUS:   rmux = {24'h0, state_q, zone_q, blink_q, obj_q, sw_q, run};
            REG_BG:       rmux = {16'h0, bg_q};
            REG_LIM1:     rmux = {16'h0, lim1_q};
            REG_LIM2:     rmux = {16'h0, lim2_q};
            REG_IRQ_STAT: rmux = {28'h0, stat_q};
            REG_IRQ_MASK: rmux = {28'h0, mask_q};
            default: begin
                for (int k = 0; k < BUF_DEPTH; k++) begin
                    if (AVS_ADDRESS == REG_BUF0 + 8'(4 * k)) begin
                        rmux = {16'h0, buf_q[k]};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            ack_q   <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
            if (AVS_READ && !ack_q) begin
                rdata_q <= rmux;
            end
        end
    end

    assign AVS_READDATA = rdata_q;

    // Software-written settings
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            ctrl_q      <= CTRL_RST;
            delay_lim_q <= DELAY_MS_RST;
            pulse_lim_q <= PULSE_MS_RST;
            idle_lim_q  <= IDLE_MS_RST;
            mask_q      <= '0;
        end else if (wr_en) begin
            case (AVS_ADDRESS)
                REG_CTRL:     if (AVS_BYTEENABLE[0]) ctrl_q <= AVS_WRITEDATA[1:0];
                REG_DELAY:    delay_lim_q <= be16(delay_lim_q, AVS_WRITEDATA, AVS_BYTEENABLE);
                REG_PULSE:    pulse_lim_q <= be16(pulse_lim_q, AVS_WRITEDATA, AVS_BYTEENABLE);
                REG_IDLE:     idle_lim_q <= be16(idle_lim_q, AVS_WRITEDATA, AVS_BYTEENABLE);
                REG_IRQ_MASK: if (AVS_BYTEENABLE[0]) mask_q <= AVS_WRITEDATA[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Sticky status; only the bits returned by the read are cleared, set wins
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            stat_q <= '0;
            irq_q  <= 1'b0;
        end else begin
            stat_q <= (rd_clr ? (stat_q & ~rdata_q[IRQ_W-1:0]) : stat_q) | ev;
            irq_q  <= |(stat_q & mask_q);
        end
    end

    assign IRQ = irq_q;

    // Checks and coverage
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);

    chk_teach_start: assert property (teach_long && run |=> state_q != ST_RUN && bg_q == $past(last_q))
        else $error("teach hold did not capture background");
    chk_delay_dark: assert property (state_q == ST_DELAY |=> led_q == 4'h0)
        else $error("indicators lit during delay");
    chk_delay_green: assert property (state_q == ST_DELAY && tick_q && done16(step_q, delay_lim_q)
        |=> run ##1 led_q == 4'hA)
        else $error("delay end did not light both green");
    chk_pulse_load: assert property ($rose(sw_q) && !mode3 |-> pulse_q == pulse_lim_q)
        else $error("pulse length not loaded");
    chk_pulse_live: assert property (sw_q && !mode3 && run && tick_q && !DIST_VALID
        && pulse_q == 16'h0000 |=> !sw_q)
        else $error("mode 2 output outlived its pulse");
    chk_m3_level: assert property (samp && mode3 |=> sw_q == $past(act3))
        else $error("mode 3 output does not follow zone");
    chk_bg_ignore: assert property (samp && mode3 && beyond |=> !sw_q)
        else $error("output active beyond background");
    chk_lim2_order: assert property (state_q == ST_WAIT_L2 && set_press && last_q <= lim1_q
        && !tick_q |=> state_q == ST_WAIT_L2)
        else $error("second limit accepted below first");
    chk_idle_exit: assert property ((state_q == ST_WAIT_L1 || state_q == ST_WAIT_L2) && tick_q
        && !set_press && !teach_edge && done16(step_q, idle_lim_q) |=> run ##1 stat_q[2])
        else $error("setup idle timeout missed");
    chk_buf_shift: assert property (push_q |=> buf_q[0] == $past(rec_q)
        && buf_q[1] == $past(buf_q[0]))
        else $error("rolling buffer did not shift");

    cov_m2_detect: cover property (det_q && !mode3 ##1 sw_q);
    cov_m3_taught: cover property (state_q == ST_WAIT_L2 ##[1:1000] state_q == ST_DELAY);
    cov_timeout:   cover property (tmo_q);

endmodule // dzs_zone_switch

// *** dzs_pkg.sv ***
// Constants, register map and types of the distance zone switch teach logic.
// Assumes a 125 MHz system clock and distances in millimetres.
package dzs_pkg;

    // Clock and time base
    localparam int CLK_HZ      = 125_000_000;
    localparam int MS_PER_S    = 1000;
    localparam int MS_TICK_CYC = CLK_HZ / MS_PER_S;

    // Times in their own units, counts in millisecond ticks
    localparam int          HOLD_S         = 1;
    localparam logic [15:0] HOLD_CNT       = 16'(HOLD_S * MS_PER_S);
    localparam int          DELAY_S        = 2;
    localparam logic [15:0] DELAY_MS_RST   = 16'(DELAY_S * MS_PER_S);
    localparam logic [15:0] PULSE_MS_RST   = 16'h00FA;
    localparam int          IDLE_S         = 30;
    localparam logic [15:0] IDLE_MS_RST    = 16'(IDLE_S * MS_PER_S);
    localparam logic [3:0]  DEBOUNCE_MS    = 4'hA;
    localparam logic [15:0] BLINK_MS       = 16'h00FA;

    // Distances in millimetres
    localparam logic [15:0] MIN_DIST_MM    = 16'h01F4;
    localparam logic [15:0] BG_RST         = 16'hFFFF;
    localparam int          BUF_DEPTH_DEF  = 5;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_DELAY    = 8'h04;
    localparam logic [7:0] REG_PULSE    = 8'h08;
    localparam logic [7:0] REG_IDLE     = 8'h0C;
    localparam logic [7:0] REG_STATUS   = 8'h10;
    localparam logic [7:0] REG_BG       = 8'h14;
    localparam logic [7:0] REG_LIM1     = 8'h18;
    localparam logic [7:0] REG_LIM2     = 8'h1C;
    localparam logic [7:0] REG_IRQ_STAT = 8'h20;
    localparam logic [7:0] REG_IRQ_MASK = 8'h24;
    localparam logic [7:0] REG_BUF0     = 8'h28;

    // Control fields and interrupt bits
    localparam int         CTRL_MODE3  = 0;
    localparam int         CTRL_REGION = 1;
    localparam logic [1:0] CTRL_RST    = 2'h0;
    localparam int         IRQ_W       = 4;

    // Mode 3 zones of the last sample
    localparam logic [1:0] ZN_NEAR = 2'h0;
    localparam logic [1:0] ZN_WIN  = 2'h1;
    localparam logic [1:0] ZN_FAR  = 2'h2;
    localparam logic [1:0] ZN_BACK = 2'h3;

    typedef enum logic [1:0] {ST_RUN, ST_WAIT_L1, ST_WAIT_L2, ST_DELAY} dzs_state_t;

endpackage

// *** dzs_operator_model.sv ***
// Operator keys and controller input on the far side of the zone switch.
// Assumes active-low keys with pull-ups, changed just after rising edges.
`timescale 1ns/100ps
module dzs_operator_model (
    input  wire logic CLOCK,
    input  wire logic SWITCH_OUT,
    output logic      teach_key_n,
    output logic      set_key_n,
    output int        len_q
);
    int run_q = 0;
    // Released keys sit at the pull-up level
    initial begin
        teach_key_n = 1'b1;
        set_key_n   = 1'b1;
    end
    // Controller input: cycles of the last output pulse
    always_ff @(posedge CLOCK) begin
        run_q <= SWITCH_OUT ? run_q + 1 : 0;
        if (!SWITCH_OUT && run_q != 0) len_q <= run_q;
    end
    // Long or short teach hold, then a settle gap for the debounce
    task automatic hold_teach(input int n);
        teach_key_n <= 1'b0;
        repeat (n) @(posedge CLOCK);
        teach_key_n <= 1'b1;
        repeat (200) @(posedge CLOCK);
    endtask
    // One set press, long enough to pass the debounce
    task automatic press_set();
        set_key_n <= 1'b0;
        repeat (200) @(posedge CLOCK);
        set_key_n <= 1'b1;
        repeat (200) @(posedge CLOCK);
    endtask
endmodule // dzs_operator_model

// *** distance_zone_switch_teach_logic_tb_top.sv ***
// Bench for the zone switch: teach in modes 2 and 3, zones, idle timeout.
// Assumes the operator model drives the keys; ms ticks shortened to 10 cycles.
`timescale 1ns/100ps
module distance_zone_switch_teach_logic_tb_top;
    import dzs_pkg::*;
    localparam int TK = 10;
    logic        CLOCK = 1'b0, SRST = 1'b1, DIST_VALID = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
    logic [15:0] DIST = 16'h0;
    logic [7:0]  AVS_ADDRESS = 8'h0;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q;
    logic        AVS_WAITREQUEST, IRQ, SWITCH_OUT, LED1_GREEN, LED1_RED, LED2_GREEN, LED2_RED;
    wire logic   tk_n, sk_n;
    int          len, error_cnt = 0, n_checks = 0;
    dzs_zone_switch #(.TICK_CYC(TK)) uut (.CLOCK, .SRST, .DIST, .DIST_VALID,
        .TEACH_KEY_N(tk_n), .SET_KEY_N(sk_n), .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
        .AVS_WRITEDATA, .AVS_BYTEENABLE(4'hF), .AVS_READDATA, .AVS_WAITREQUEST, .IRQ,
        .SWITCH_OUT, .LED1_GREEN, .LED1_RED, .LED2_GREEN, .LED2_RED);
    dzs_operator_model op (.CLOCK, .SWITCH_OUT, .teach_key_n(tk_n), .set_key_n(sk_n), .len_q(len));
    always #4 CLOCK = ~CLOCK;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Held until waitrequest is low at a rising edge; idle cycle after, no double drive
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
        q = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        @(posedge CLOCK);
    endtask
    task automatic smp(input logic [15:0] d);
        DIST <= d;
        DIST_VALID <= 1'b1;
        @(posedge CLOCK);
        DIST_VALID <= 1'b0;
        repeat (4) @(posedge CLOCK);
    endtask
    task automatic t_reset();
        chk({SWITCH_OUT, LED1_GREEN, LED2_GREEN, LED1_RED, LED2_RED, IRQ}, 32'h18);
        bus(0, REG_DELAY, 0); chk(q, 32'(DELAY_MS_RST));
        bus(0, REG_PULSE, 0); chk(q, 32'(PULSE_MS_RST));
        bus(0, 8'h40, 0); chk(q, 32'h0);
    endtask
    task automatic t_mode2();
        bus(1, REG_DELAY, 32'h64); bus(1, REG_PULSE, 32'hA); bus(1, REG_IRQ_MASK, 32'hF);
        smp(16'hBB8);
        op.hold_teach(500 * TK); chk(LED1_GREEN, 1'b1);
        op.hold_teach(1050 * TK); chk({LED1_GREEN, LED2_GREEN}, 2'h0);
        repeat (80 * TK) @(posedge CLOCK);
        chk({LED1_GREEN, LED2_GREEN}, 2'h3);
        bus(0, REG_IRQ_STAT, 0);
        smp(16'h3E8); chk(SWITCH_OUT, 1'b0);
        smp(16'hBB8); chk({SWITCH_OUT, LED1_GREEN, LED2_GREEN}, 3'h4);
        repeat (300 * TK) @(posedge CLOCK);
        chk(len >= 10 * TK && len <= 12 * TK, 1'b1);
        chk(IRQ, 1'b1);
        bus(0, REG_IRQ_STAT, 0); chk(q & 32'h9, 32'h9);
        bus(0, REG_BUF0, 0); chk(q, 32'h3E8);
        smp(16'h1388); chk(SWITCH_OUT, 1'b0);
    endtask
    task automatic t_mode3();
        bus(1, REG_CTRL, 32'h1); smp(16'hFA0);
        op.hold_teach(1050 * TK); bus(0, REG_STATUS, 0); chk(q[7:6], 2'h1);
        smp(16'h3E8); op.press_set(); bus(0, REG_STATUS, 0);
        chk({LED1_GREEN, q[7:6]}, 3'h6);
        smp(16'h320); op.press_set(); bus(0, REG_STATUS, 0); chk(q[7:6], 2'h2);
        smp(16'h7D0); op.press_set(); chk({LED1_GREEN, LED2_GREEN}, 2'h0);
        repeat (80 * TK) @(posedge CLOCK); chk({LED1_GREEN, LED2_GREEN}, 2'h3);
        bus(0, REG_LIM2, 0); chk(q, 32'h7D0);
    endtask
    // Window first, then outer zones; last entry is below the minimum range
    task automatic t_zones();
        logic [15:0] d [9] = '{16'h5DC, 16'h2BC, 16'hBB8, 16'h1388, 16'h2BC, 16'h5DC,
                               16'hBB8, 16'h1388, 16'h190};
        logic [2:0]  e [9] = '{3'h4, 3'h2, 3'h1, 3'h0, 3'h6, 3'h0, 3'h5, 3'h0, 3'h2};
        for (int i = 0; i < 9; i++) begin
            if (i == 4) bus(1, REG_CTRL, 32'h3);
            smp(d[i]);
            chk({SWITCH_OUT, LED1_RED, LED2_RED}, e[i]);
            if (i == 3) chk({LED1_GREEN, LED2_GREEN}, 2'h3);
        end
    endtask
    task automatic t_timeout();
        bus(1, REG_IDLE, 32'hC8); bus(0, REG_IRQ_STAT, 0);
        op.hold_teach(1050 * TK); bus(0, REG_STATUS, 0); chk(q[7:6], 2'h1);
        repeat (250 * TK) @(posedge CLOCK);
        bus(0, REG_STATUS, 0); chk(q[7:6], 2'h0);
        bus(0, REG_IRQ_STAT, 0); chk(q[2], 1'b1);
    endtask
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge CLOCK);
        SRST <= 1'b0;
        @(posedge CLOCK);
        t_reset(); t_mode2(); t_mode3(); t_zones(); t_timeout();
        report_and_stop();
    end
    // Watchdog: about twice the expected run
    initial begin
        repeat (100000) @(posedge CLOCK);
        error_cnt++;
        report_and_stop();
    end
endmodule // distance_zone_switch_teach_logic_tb_top
